// ---- bench/pinio_bank_sva.sv ----
/*
 * Port assertions for pinio_bank, bound to every instance below.
 * Assumes the one-cycle strobe register port and the two-flop reset release of the design.
 */
`timescale 1ns/10ps
module pinio_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reg_wr_en,
    input wire logic serial_ctrl_mode,
    input wire logic user_pins_global_on,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [4:0] user_pin_dir,
    input wire logic [4:0] user_pin_out,
    input wire logic [4:0] user_pin_oe,
    input wire logic [7:0] ch_input_buf_p_on,
    input wire logic [7:0] ch_input_buf_n_on,
    input wire logic [7:0] ch_ref_plus_buffer_on,
    input wire logic [7:0] ch_ref_minus_buffer_on
);
    logic [2:0] rst_pipe_q;
    wire logic [127:0] wr_at = {127'h0, reg_wr_en} << reg_addr;

    // follows the design's reset release, one stage later so registered outputs have settled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe_q <= 3'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[1:0], 1'b1};
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n || !rst_pipe_q[2]);
    AST_REFP: assert property (wr_at['h13] |=> ch_ref_plus_buffer_on == $past(reg_wdata)) else $error("refp");
    AST_REFN: assert property (wr_at['h14] |=> ch_ref_minus_buffer_on == $past(reg_wdata)) else $error("refn");
    AST_INLO: assert property (wr_at['h11] |=> ch_input_buf_p_on[0] != $past(reg_wdata[0])) else $error("in0");
    AST_INHI: assert property (wr_at['h12] |=> ch_input_buf_n_on[7] != $past(reg_wdata[7])) else $error("in7");
    AST_OE: assert property (user_pin_oe == $past(user_pin_dir & {5{serial_ctrl_mode & user_pins_global_on}}))
        else $error("pin enable");
    AST_OFF: assert property ((user_pin_out & ~user_pin_oe) == 5'h00) else $error("drive while off");
    AST_OUT: assert property (wr_at['h0f] ##1 !wr_at['h0f] |=> user_pin_out == ($past(reg_wdata[4:0], 2) & user_pin_oe))
        else $error("pin value");
    AST_HOLD: assert property (!reg_wr_en |=> $stable(ch_ref_plus_buffer_on)) else $error("ref moved");
endmodule // pinio_chk
bind pinio_bank pinio_chk i_chk (
    .clk(clk),
    .arst_n(arst_n),
    .reg_wr_en(reg_wr_en),
    .serial_ctrl_mode(serial_ctrl_mode),
    .user_pins_global_on(user_pins_global_on),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .user_pin_dir(user_pin_dir),
    .user_pin_out(user_pin_out),
    .user_pin_oe(user_pin_oe),
    .ch_input_buf_p_on(ch_input_buf_p_on),
    .ch_input_buf_n_on(ch_input_buf_n_on),
    .ch_ref_plus_buffer_on(ch_ref_plus_buffer_on),
    .ch_ref_minus_buffer_on(ch_ref_minus_buffer_on)
);

// ---- bench/testbench.sv ----
/* self-checking bench for pinio_bank; the bench drives the register port through strobe tasks and the pin-control levels directly */
`timescale 1ns/10ps
module testbench;
    logic clk = 0, arst_n = 0, reg_wr_en = 0, reg_rd_en = 0, serial_ctrl_mode = 0, user_pins_global_on = 0;
    logic [6:0] reg_addr = 0;
    logic [4:0] user_pin_dir = 5'h0f, user_pin_in = 5'h15, user_pin_out, user_pin_oe;
    logic [7:0] reg_wdata = 0, reg_rdata, ch_input_buf_p_on, ch_input_buf_n_on;
    logic [7:0] ch_ref_plus_buffer_on, ch_ref_minus_buffer_on;
    int bad_count = 0, n_tests = 0, cyc = 0;
    pinio_bank i_dut (
        .clk(clk),
        .arst_n(arst_n),
        .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .serial_ctrl_mode(serial_ctrl_mode),
        .user_pins_global_on(user_pins_global_on),
        .user_pin_dir(user_pin_dir),
        .user_pin_in(user_pin_in),
        .user_pin_out(user_pin_out),
        .user_pin_oe(user_pin_oe),
        .ch_input_buf_p_on(ch_input_buf_p_on),
        .ch_input_buf_n_on(ch_input_buf_n_on),
        .ch_ref_plus_buffer_on(ch_ref_plus_buffer_on),
        .ch_ref_minus_buffer_on(ch_ref_minus_buffer_on)
    );
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [7:0] got, exp);
        n_tests++;
        bad_count += int'(got !== exp);
        if (got !== exp) $display("[ERR] %0t got %h want %h", $time, got, exp);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        @(posedge clk);
        chk(reg_rdata, e);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 7; i++) rd(7'(15 + i), (i == 2 || i == 3) ? 8'hff : 8'h00);
        wr(7'h11, 8'h01);
        wr(7'h12, 8'h80);
        rd(7'h11, 8'hfe);
        rd(7'h12, 8'h7f);
        chk(ch_input_buf_p_on, 8'hfe);
        chk(ch_input_buf_n_on, 8'h7f);
        wr(7'h13, 8'ha5);
        rd(7'h13, 8'ha5);
        wr(7'h14, 8'h5a);
        rd(7'h14, 8'h5a);
        chk(ch_ref_plus_buffer_on, 8'ha5);
        chk(ch_ref_minus_buffer_on, 8'h5a);
        wr(7'h10, 8'hff);
        rd(7'h10, 8'h00);
        wr(7'h0f, 8'hff);
        rd(7'h0f, 8'h1f);
        chk({3'h0, user_pin_out}, 8'h00);
        {serial_ctrl_mode, user_pins_global_on} <= 2'b11;
        repeat (3) @(posedge clk);
        rd(7'h10, 8'h10);
        chk({3'h0, user_pin_out}, 8'h0f);
        chk({3'h0, user_pin_oe}, 8'h0f);
        wr(7'h0f, 8'h05);
        @(posedge clk);
        chk({3'h0, user_pin_out}, 8'h05);
        user_pins_global_on <= 1'b0;
        repeat (2) @(posedge clk);
        rd(7'h10, 8'h00);
        chk({3'h0, user_pin_oe}, 8'h00);
        chk({3'h0, user_pin_out}, 8'h00);
        user_pins_global_on <= 1'b1;
        user_pin_dir <= 5'h00;
        repeat (2) @(posedge clk);
        rd(7'h10, 8'h15);
        chk({3'h0, user_pin_oe}, 8'h00);
        serial_ctrl_mode <= 1'b0;
        repeat (2) @(posedge clk);
        rd(7'h10, 8'h00);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(ch_input_buf_p_on, 8'hff);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(7'h11, 8'hff);
        rd(7'h0f, 8'h00);
        chk(ch_ref_plus_buffer_on, 8'h00);
        complete_run;
    end
    always @(posedge clk) if (++cyc == 400) begin
        bad_count++;
        complete_run;
    end
    task automatic complete_run;
        $display("tests %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
endmodule // testbench

// ---- common/pinio_pkg.sv ----
/*
 * Types of the user-pin and precharge register bank.
 * Assumes pinio_regs.svh is on the include path.
 */
`include "pinio_regs.svh"

package pinio_pkg;
    typedef logic [`PINIO_ADDR_W-1:0] pinio_addr_t;
    typedef logic [`PINIO_DATA_W-1:0] pinio_byte_t;
    typedef logic [`PINIO_NPINS-1:0] pinio_pins_t;
    typedef logic [`PINIO_NCH-1:0] pinio_chan_t;
endpackage

// ---- common/pinio_regs.svh ----
/*
 * Offsets, field positions and reset values of the user-pin and precharge register bank.
 * Assumes inclusion by the package and the design module only.
 */
// Summary of operation
// - output-value register at 0x0f, reset zero, low five bits drive output pins.
// - bit 4 drives the filter strap pin, bits 3..0 the mode strap pins.
// - read-only input-level register at 0x10 returns sampled levels of input pins.
// - input precharge register 0x11 resets to ones; channels 0-3, even bit positive side.
// - input precharge register 0x12 resets to ones; channels 4-7, channel 4 in bits 1:0.
// - both input precharge registers store the complement of each written byte.
// - positive reference buffer register 0x13, reset zero, bit n enables channel n.
// - negative reference buffer register 0x14, reset zero, bit n enables channel n.
// - user pins work only in serial control mode with global pin enable set.
// - each pin's direction bit selects input on zero and output on one.
`ifndef PINIO_REGS_SVH
`define PINIO_REGS_SVH

`define PINIO_ADDR_W 7
`define PINIO_DATA_W 8
`define PINIO_NPINS 5
`define PINIO_NCH 8

`define PINIO_OFS_OUT_VALUES 7'h0f
`define PINIO_OFS_IN_LEVELS 7'h10
`define PINIO_OFS_INBUF_LOW 7'h11
`define PINIO_OFS_INBUF_HIGH 7'h12
`define PINIO_OFS_REFP 7'h13
`define PINIO_OFS_REFN 7'h14

`define PINIO_RST_OUT_VALUES 8'h00
`define PINIO_RST_IN_LEVELS 8'h00
`define PINIO_RST_INBUF 8'hff
`define PINIO_RST_REF 8'h00

`define PINIO_PIN_FILTER 4
`define PINIO_PIN_MSB 4

`endif

// ---- src/pinio_bank.sv ----
/*
 * Register bank for five dual-purpose user pins and the per-channel precharge buffer enables.
 * Assumes the serial control port decodes frames and presents one-cycle read and write strobes
 * synchronous to clk; pin enable, pin directions and control mode come from elsewhere as levels.
 */
`timescale 1ns/10ps
`include "pinio_regs.svh"

module pinio_bank (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire pinio_pkg::pinio_addr_t reg_addr,
    input wire pinio_pkg::pinio_byte_t reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic serial_ctrl_mode,
    input wire logic user_pins_global_on,
    input wire pinio_pkg::pinio_pins_t user_pin_dir,
    input wire pinio_pkg::pinio_pins_t user_pin_in,
    output pinio_pkg::pinio_pins_t user_pin_out,
    output pinio_pkg::pinio_pins_t user_pin_oe,
    output pinio_pkg::pinio_chan_t ch_input_buf_p_on,
    output pinio_pkg::pinio_chan_t ch_input_buf_n_on,
    output pinio_pkg::pinio_chan_t ch_ref_plus_buffer_on,
    output pinio_pkg::pinio_chan_t ch_ref_minus_buffer_on
);
    import pinio_pkg::*;

    function automatic logic hit(input pinio_addr_t a, input pinio_addr_t ofs);
        hit = (a == ofs);
    endfunction

    // bit positions of the positive and negative input buffer enables of a channel
    function automatic int pos_bit(input int ch);
        pos_bit = 2 * ch;
    endfunction

    function automatic int neg_bit(input int ch);
        neg_bit = 2 * ch + 1;
    endfunction

    logic rst_sync1_q;
    logic rst_n_q;
    pinio_byte_t out_values_q;
    pinio_byte_t out_values_d;
    pinio_byte_t in_levels_q;
    pinio_byte_t in_levels_d;
    pinio_byte_t inbuf_low_q;
    pinio_byte_t inbuf_low_d;
    pinio_byte_t inbuf_high_q;
    pinio_byte_t inbuf_high_d;
    pinio_byte_t refp_q;
    pinio_byte_t refp_d;
    pinio_byte_t refn_q;
    pinio_byte_t refn_d;
    pinio_byte_t read_mux;
    pinio_byte_t rdata_q;
    pinio_byte_t rdata_d;
    pinio_pins_t pin_out_q;
    pinio_pins_t pin_oe_q;
    wire pinio_pins_t pin_out_d;

    // pins act as general-purpose pins only in serial control mode with the global enable set
    wire pins_active = serial_ctrl_mode & user_pins_global_on;
    wire pinio_pins_t oe_d = pins_active ? user_pin_dir : '0;
    wire pinio_pins_t in_sel = pins_active ? ~user_pin_dir : '0;

    // address decode, shared by the write strobes and the read mux
    wire sel_out = hit(reg_addr, `PINIO_OFS_OUT_VALUES);
    wire sel_in = hit(reg_addr, `PINIO_OFS_IN_LEVELS);
    wire sel_low = hit(reg_addr, `PINIO_OFS_INBUF_LOW);
    wire sel_high = hit(reg_addr, `PINIO_OFS_INBUF_HIGH);
    wire sel_refp = hit(reg_addr, `PINIO_OFS_REFP);
    wire sel_refn = hit(reg_addr, `PINIO_OFS_REFN);

    // the input-level register has no write strobe, so writes to it are dropped
    wire wr_out = reg_wr_en & sel_out;
    wire wr_low = reg_wr_en & sel_low;
    wire wr_high = reg_wr_en & sel_high;
    wire wr_refp = reg_wr_en & sel_refp;
    wire wr_refn = reg_wr_en & sel_refn;

    // reset release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_n_q <= rst_sync1_q;
        end
    end

    // bits 7:5 of the output-value register are not implemented and read zero
    assign out_values_d = wr_out
        ? {3'h0, reg_wdata[`PINIO_PIN_MSB:0]}
        : out_values_q;

    // the input buffer registers keep the complement of the written byte
    assign inbuf_low_d = wr_low
        ? ~reg_wdata
        : inbuf_low_q;
    assign inbuf_high_d = wr_high
        ? ~reg_wdata
        : inbuf_high_q;

    assign refp_d = wr_refp
        ? reg_wdata
        : refp_q;
    assign refn_d = wr_refn
        ? reg_wdata
        : refn_q;

    // only enabled input pins are sampled, the others read zero
    assign in_levels_d = {3'h0, user_pin_in & in_sel};

    // read data changes only on a read strobe; a write in the same cycle is not yet visible
    assign rdata_d = reg_rd_en
        ? read_mux
        : rdata_q;

    // each pin drives its stored value only while it is an enabled output
    genvar p;
    generate
        for (p = 0; p < `PINIO_NPINS; p = p + 1) begin : g_pin
            assign pin_out_d[p] = out_values_q[p] & oe_d[p];
        end
    endgenerate

    // one-hot read select; unmapped addresses read zero
    assign read_mux = ({8{sel_out}} & out_values_q)
        | ({8{sel_in}} & in_levels_q)
        | ({8{sel_low}} & inbuf_low_q)
        | ({8{sel_high}} & inbuf_high_q)
        | ({8{sel_refp}} & refp_q)
        | ({8{sel_refn}} & refn_q);

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_values_q <= `PINIO_RST_OUT_VALUES;
        end else begin
            out_values_q <= out_values_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            in_levels_q <= `PINIO_RST_IN_LEVELS;
        end else begin
            in_levels_q <= in_levels_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            inbuf_low_q <= `PINIO_RST_INBUF;
        end else begin
            inbuf_low_q <= inbuf_low_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            inbuf_high_q <= `PINIO_RST_INBUF;
        end else begin
            inbuf_high_q <= inbuf_high_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            refp_q <= `PINIO_RST_REF;
        end else begin
            refp_q <= refp_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            refn_q <= `PINIO_RST_REF;
        end else begin
            refn_q <= refn_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_out_q <= '0;
        end else begin
            pin_out_q <= pin_out_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_oe_q <= '0;
        end else begin
            pin_oe_q <= oe_d;
        end
    end

    // channel c (low register) or c+4 (high register) of the input buffers uses bits 2c (positive) and 2c+1 (negative)
    genvar c;
    generate
        for (c = 0; c < `PINIO_NCH / 2; c = c + 1) begin : g_inbuf_low
            assign ch_input_buf_p_on[c] = inbuf_low_q[pos_bit(c)];
            assign ch_input_buf_n_on[c] = inbuf_low_q[neg_bit(c)];
        end
        for (c = 0; c < `PINIO_NCH / 2; c = c + 1) begin : g_inbuf_high
            assign ch_input_buf_p_on[c + `PINIO_NCH / 2] = inbuf_high_q[pos_bit(c)];
            assign ch_input_buf_n_on[c + `PINIO_NCH / 2] = inbuf_high_q[neg_bit(c)];
        end
    endgenerate

    assign ch_ref_plus_buffer_on = refp_q;
    assign ch_ref_minus_buffer_on = refn_q;
    assign user_pin_out = pin_out_q;
    assign user_pin_oe = pin_oe_q;
    assign reg_rdata = rdata_q;
endmodule // pinio_bank
